/* core/timer_cc_core.sv */
// Eight-channel 16-bit capture/compare timer with Wishbone register access.
`timescale 1ns/1ps
`default_nettype none
module timer_cc_core #(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Timer pins
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOe,
  // Interrupt requests
  output logic      [7:0]  chIrq,
  output logic             paInputIrq,
  output logic             paOverflowIrq,
  output logic             counterOverflowIrq
);

  if (NUM_CH != 8) begin : g_bad_width
    $error("channel 7 override logic serves exactly eight channels");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]         sync1;
    logic [7:0]         sync2;
    logic [7:0]         prev;
    logic [6:0]         preCnt;
    logic [15:0]        count;
    logic [7:0][15:0]   chValue;
    logic               timerOn;
    logic               cntResetOn7;
    logic [2:0]         preSel;
    logic               cntOvfIrqEn;
    logic               cntOvfFlag;
    logic [7:0]         ccSelect;
    logic [15:0]        actionCfg;
    logic [15:0]        captEdge;
    logic [7:0]         chIrqEn;
    logic [7:0]         chFlag;
    logic [7:0]         ch7Mask;
    logic [7:0]         ch7Data;
    logic [7:0]         portData;
    logic [7:0]         portDir;
    logic [7:0]         cmpOut;
    timer_pkg::pa_cfg_s paCfg;
    logic               ack;
    logic [31:0]        rdata;
  } core_state_s;

  core_state_s s;
  core_state_s n;
  logic        reqTake;
  logic        wrEn;
  logic [6:0]  preMask;
  logic        tick;
  logic        div64Tick;
  logic        ch7Reset;
  logic [7:0]  forceW;
  logic [7:0]  capt;
  logic [7:0]  match;
  logic [7:0]  act;
  logic [7:0]  owned;
  logic [15:0] paCount;
  logic        paInFlag;
  logic        paOvfFlag;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  // ****************************************
  // Bus, prescaler and channel decode
  // ****************************************
  assign reqTake   = cyc_i & stb_i & ~s.ack;
  assign wrEn      = reqTake & we_i;
  assign preMask   = 7'((8'h01 << s.preSel) - 8'h01);
  assign tick      = s.timerOn & (&(s.preCnt | ~preMask));
  assign div64Tick = s.timerOn & (s.preCnt[5:0] == timer_pkg::DIV64_LAST);
  assign ch7Reset  = match[7] & s.cntResetOn7;
  assign forceW    = (wrEn && hit(adr_i, timer_pkg::FORCE_OFS) && sel_i[0]) ? dat_i[7:0] : 8'h00;

  for (genvar i = 0; i < 8; i++) begin : g_ch
    logic rise;
    logic fall;
    assign rise = s.sync2[i] & ~s.prev[i];
    assign fall = ~s.sync2[i] & s.prev[i];
    assign capt[i] = ~s.ccSelect[i]
                   & ((s.captEdge[2*i] & rise) | (s.captEdge[2*i+1] & fall));
    assign match[i] = s.ccSelect[i] & tick & (s.count == s.chValue[i]);
    assign act[i] = s.ccSelect[i] & (match[i] | forceW[i]);
    // Channel 7 mask takes the pin even when its own action pair is off.
    assign owned[i] = s.ccSelect[i]
                    & ((s.actionCfg[2*i +: 2] != timer_pkg::ACT_OFF) | s.ch7Mask[i]);
    assign pinOut[i] = owned[i] ? s.cmpOut[i] : s.portData[i];
    assign pinOe[i]  = owned[i] | s.portDir[i];
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    n = s;
    n.ack   = reqTake;
    n.sync1 = pinIn;
    n.sync2 = s.sync1;
    n.prev  = s.sync2;
    n.preCnt = s.timerOn ? s.preCnt + 7'h01 : 7'h00;
    if (tick) begin
      n.count = ch7Reset ? timer_pkg::COUNT_RST : s.count + 16'h0001;
    end
    for (int i = 0; i < 8; i++) begin
      if (act[i]) begin
        case (s.actionCfg[2*i +: 2])
          timer_pkg::ACT_TOGGLE: n.cmpOut[i] = ~s.cmpOut[i];
          timer_pkg::ACT_CLEAR:  n.cmpOut[i] = 1'b0;
          timer_pkg::ACT_SET:    n.cmpOut[i] = 1'b1;
          default:               n.cmpOut[i] = s.cmpOut[i];
        endcase
      end
    end
    // Applied last so that channel 7 wins over any other compare.
    if (act[7]) begin
      for (int i = 0; i < 8; i++) begin
        if (s.ch7Mask[i]) begin
          n.cmpOut[i] = s.ch7Data[i];
        end
      end
    end
    if (wrEn) begin
      if (hit(adr_i, timer_pkg::CTRL_OFS) && sel_i[0]) begin
        n.timerOn     = dat_i[timer_pkg::CTRL_ON_BIT];
        n.cntResetOn7 = dat_i[timer_pkg::CTRL_RST7_BIT];
        n.preSel      = dat_i[timer_pkg::CTRL_PRE_LSB +: 3];
        n.cntOvfIrqEn = dat_i[timer_pkg::CTRL_OVFIE_BIT];
      end
      if (hit(adr_i, timer_pkg::SELECT_OFS) && sel_i[0]) begin
        n.ccSelect = dat_i[7:0];
      end
      if (hit(adr_i, timer_pkg::ACTION_OFS)) begin
        n.actionCfg = timer_pkg::merge16(s.actionCfg, dat_i[15:0], sel_i[1:0]);
      end
      if (hit(adr_i, timer_pkg::CAPTEDGE_OFS)) begin
        n.captEdge = timer_pkg::merge16(s.captEdge, dat_i[15:0], sel_i[1:0]);
      end
      if (hit(adr_i, timer_pkg::CHIRQEN_OFS) && sel_i[0]) begin
        n.chIrqEn = dat_i[7:0];
      end
      if (hit(adr_i, timer_pkg::CH7_OFS)) begin
        {n.ch7Data, n.ch7Mask} = timer_pkg::merge16({s.ch7Data, s.ch7Mask}, dat_i[15:0],
                                                    sel_i[1:0]);
      end
      // Port data is always stored, whoever owns the pin.
      if (hit(adr_i, timer_pkg::PORT_OFS)) begin
        {n.portDir, n.portData} = timer_pkg::merge16({s.portDir, s.portData}, dat_i[15:0],
                                                     sel_i[1:0]);
      end
      if (hit(adr_i, timer_pkg::PACTRL_OFS) && sel_i[0]) begin
        n.paCfg.enable   = dat_i[timer_pkg::PA_EN_BIT];
        n.paCfg.modeSel  = dat_i[timer_pkg::PA_MODE_BIT];
        n.paCfg.edgeSel  = dat_i[timer_pkg::PA_EDGE_BIT];
        n.paCfg.ovfIrqEn = dat_i[timer_pkg::PA_OVFIE_BIT];
        n.paCfg.inIrqEn  = dat_i[timer_pkg::PA_INIE_BIT];
      end
      if (adr_i[7:5] == timer_pkg::CHVAL_OFS[7:5]) begin
        n.chValue[adr_i[4:2]] = timer_pkg::merge16(s.chValue[adr_i[4:2]], dat_i[15:0],
                                                   sel_i[1:0]);
      end
    end
    // A capture in the same cycle as a software write keeps the captured time.
    for (int i = 0; i < 8; i++) begin
      if (capt[i]) begin
        n.chValue[i] = s.count;
      end
    end
    // Set wins over a simultaneous write-one clear.
    n.chFlag = s.chFlag & ~((wrEn && hit(adr_i, timer_pkg::FLAGS_OFS) && sel_i[0])
                            ? dat_i[7:0] : 8'h00);
    n.chFlag = n.chFlag | capt | match;
    n.cntOvfFlag = (s.cntOvfFlag & ~(wrEn && hit(adr_i, timer_pkg::FLAGS_OFS) && sel_i[1]
                                     && dat_i[timer_pkg::FLAGS_OVF_BIT]))
                 | (tick & ~ch7Reset & (s.count == timer_pkg::COUNT_MAX));
    if (reqTake && !we_i) begin
      n.rdata = 32'h0000_0000;
      case (adr_i[7:2])
        timer_pkg::CTRL_OFS[7:2]:
          n.rdata[5:0] = {s.cntOvfIrqEn, s.preSel, s.cntResetOn7, s.timerOn};
        timer_pkg::SELECT_OFS[7:2]:   n.rdata[7:0]  = s.ccSelect;
        timer_pkg::ACTION_OFS[7:2]:   n.rdata[15:0] = s.actionCfg;
        timer_pkg::CAPTEDGE_OFS[7:2]: n.rdata[15:0] = s.captEdge;
        timer_pkg::CHIRQEN_OFS[7:2]:  n.rdata[7:0]  = s.chIrqEn;
        timer_pkg::FLAGS_OFS[7:2]:    n.rdata[8:0]  = {s.cntOvfFlag, s.chFlag};
        timer_pkg::COUNT_OFS[7:2]:    n.rdata[15:0] = s.count;
        timer_pkg::CH7_OFS[7:2]:      n.rdata[15:0] = {s.ch7Data, s.ch7Mask};
        timer_pkg::PORT_OFS[7:2]:     n.rdata[15:0] = {s.portDir, s.portData};
        timer_pkg::PACTRL_OFS[7:2]:   n.rdata[4:0]  = s.paCfg;
        timer_pkg::PAFLAG_OFS[7:2]:   n.rdata[1:0]  = {paOvfFlag, paInFlag};
        timer_pkg::PACOUNT_OFS[7:2]:  n.rdata[15:0] = paCount;
        default: begin
          if (adr_i[7:5] == timer_pkg::CHVAL_OFS[7:5]) begin
            n.rdata[15:0] = s.chValue[adr_i[4:2]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // Pulse accumulator and outputs
  // ****************************************
  timer_pulse_accum u_accum (
    .clk       (clk),
    .rst_b     (rst_b),
    .pinLevel  (s.sync2[7]),
    .div64Tick (div64Tick),
    .cfg       (s.paCfg),
    .countWr   (wrEn && hit(adr_i, timer_pkg::PACOUNT_OFS)),
    .countData (dat_i[15:0]),
    .countSel  (sel_i[1:0]),
    .flagClr   ((wrEn && hit(adr_i, timer_pkg::PAFLAG_OFS) && sel_i[0]) ? dat_i[1:0] : 2'h0),
    .count     (paCount),
    .inFlag    (paInFlag),
    .ovfFlag   (paOvfFlag)
  );

  assign dat_o              = s.rdata;
  assign ack_o              = s.ack;
  assign chIrq              = s.chFlag & s.chIrqEn;
  assign paInputIrq         = paInFlag & s.paCfg.inIrqEn;
  assign paOverflowIrq      = paOvfFlag & s.paCfg.ovfIrqEn;
  assign counterOverflowIrq = s.cntOvfFlag & s.cntOvfIrqEn;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence ch7_hit_s;
    match[7] && s.cntResetOn7;
  endsequence

  sequence counter_cleared_s;
    s.count == 16'h0000 ##1 s.count <= 16'h0001;
  endsequence

  chk_capture_time: assert property (capt[2] |=> s.chValue[2] == $past(s.count))
    else $error("capture did not latch counter");
  chk_capture_irq: assert property (capt[2] && s.chIrqEn[2] |=> chIrq[2])
    else $error("capture irq missing");
  chk_compare_flag: assert property (match[1] |=> s.chFlag[1])
    else $error("compare flag not set");
  chk_set_action: assert property (match[1] && !(act[7] && s.ch7Mask[1]) && s.actionCfg[3:2] == 2'h3
    |=> s.cmpOut[1]) else $error("set action failed");
  chk_pin_released: assert property (s.ccSelect[1] && s.actionCfg[3:2] == 2'h0
    && !s.ch7Mask[1] |-> pinOut[1] == s.portData[1]) else $error("pin not disconnected");
  chk_force_noflag: assert property (forceW[1] && !match[1] && !capt[1] && !s.chFlag[1]
    |=> !s.chFlag[1]) else $error("force set flag");
  chk_ch7_wins: assert property (act[7] && s.ch7Mask[1]
    |=> s.cmpOut[1] == $past(s.ch7Data[1])) else $error("channel 7 override lost");
  chk_counter_reset: assert property (ch7_hit_s |=> counter_cleared_s)
    else $error("channel 7 did not reset counter");
  chk_port_latch: assert property (wrEn && hit(adr_i, timer_pkg::PORT_OFS) && owned[1]
    && !act[1] && !act[7] |=> pinOut[1] == $past(pinOut[1])) else $error("port write moved owned pin");

endmodule : timer_cc_core
`default_nettype wire

/* core/timer_pkg.sv */
// Shared constants, types and helpers of the capture/compare timer.
`default_nettype none
package timer_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] SELECT_OFS   = 8'h04;
  localparam logic [7:0] FORCE_OFS    = 8'h08;
  localparam logic [7:0] ACTION_OFS   = 8'h0C;
  localparam logic [7:0] CAPTEDGE_OFS = 8'h10;
  localparam logic [7:0] CHIRQEN_OFS  = 8'h14;
  localparam logic [7:0] FLAGS_OFS    = 8'h18;
  localparam logic [7:0] COUNT_OFS    = 8'h1C;
  localparam logic [7:0] CH7_OFS      = 8'h20;
  localparam logic [7:0] PORT_OFS     = 8'h24;
  localparam logic [7:0] PACTRL_OFS   = 8'h28;
  localparam logic [7:0] PAFLAG_OFS   = 8'h2C;
  localparam logic [7:0] PACOUNT_OFS  = 8'h30;
  localparam logic [7:0] CHVAL_OFS    = 8'h40;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int CTRL_ON_BIT    = 0;
  localparam int CTRL_RST7_BIT  = 1;
  localparam int CTRL_PRE_LSB   = 2;
  localparam int CTRL_OVFIE_BIT = 5;
  localparam int FLAGS_OVF_BIT  = 8;
  localparam int PA_INIE_BIT    = 0;
  localparam int PA_OVFIE_BIT   = 1;
  localparam int PA_EDGE_BIT    = 2;
  localparam int PA_MODE_BIT    = 3;
  localparam int PA_EN_BIT      = 4;
  localparam int PA_INF_BIT     = 0;
  localparam int PA_OVF_BIT     = 1;
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [5:0]  DIV64_LAST = 6'h3F;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic enable;
    logic modeSel;
    logic edgeSel;
    logic ovfIrqEn;
    logic inIrqEn;
  } pa_cfg_s;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] dat,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge16

endpackage : timer_pkg
`default_nettype wire

/* core/timer_pulse_accum.sv */
// Sixteen-bit pulse accumulator fed by the shared channel 7 pin.
`timescale 1ns/1ps
`default_nettype none
module timer_pulse_accum (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Pin level, already synchronised, and prescaler enable
  input  wire logic               pinLevel,
  input  wire logic               div64Tick,
  // Configuration and software access
  input  wire timer_pkg::pa_cfg_s cfg,
  input  wire logic               countWr,
  input  wire logic [15:0]        countData,
  input  wire logic [1:0]         countSel,
  input  wire logic [1:0]         flagClr,
  // State
  output logic [15:0]             count,
  output logic                    inFlag,
  output logic                    ovfFlag
);

  typedef struct packed {
    logic        prev;
    logic [15:0] count;
    logic        inFlag;
    logic        ovfFlag;
  } pa_state_s;

  pa_state_s s;
  pa_state_s n;
  logic      edgeEv;
  logic      inc;

  // Trailing edge of the active gate level coincides with the counted edge.
  assign edgeEv = cfg.enable & (cfg.edgeSel ? (pinLevel & ~s.prev) : (~pinLevel & s.prev));
  // div64Tick is already gated off while the timer is stopped.
  assign inc = cfg.modeSel ? (cfg.enable & div64Tick & (pinLevel ^ cfg.edgeSel))
                           : edgeEv;

  always_comb begin
    n = s;
    n.prev = pinLevel;
    if (countWr) begin
      n.count = timer_pkg::merge16(s.count, countData, countSel);
    end else if (inc) begin
      n.count = s.count + 16'h0001;
    end
    n.inFlag = (s.inFlag & ~flagClr[0]) | edgeEv;
    n.ovfFlag = (s.ovfFlag & ~flagClr[1]) | (inc & ~countWr & (s.count == timer_pkg::COUNT_MAX));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign count   = s.count;
  assign inFlag  = s.inFlag;
  assign ovfFlag = s.ovfFlag;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_event_count: assert property (cfg.enable && !cfg.modeSel && edgeEv && !countWr
    |=> s.count == $past(s.count) + 16'h0001) else $error("event edge not counted");
  chk_wrap_flag: assert property (inc && !countWr && s.count == 16'hFFFF
    |=> s.count == 16'h0000 && s.ovfFlag) else $error("wrap did not set overflow");
  chk_gate_stop: assert property (cfg.modeSel && !div64Tick && !countWr
    |=> $stable(s.count)) else $error("gated count moved without tick");
  chk_input_clear: assert property (flagClr[0] && !edgeEv
    |=> !s.inFlag) else $error("input flag not cleared");

endmodule : timer_pulse_accum
`default_nettype wire

/* verif/timer_capture_compare_pulse_accum_tb.sv */
// Self-checking bench of the capture/compare timer core.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_pulse_accum_tb;
  // ****************
  // Signals and parts
  // ****************
  logic        clk = 1'b0;
  logic        rst_b, cyc, stb, we, ack, paIn, pulse_overflow_flag, cntOvf, cur;
  logic [7:0]  adr, pinIn, pinOut, pinOe, chIrq;
  logic [3:0]  sel;
  logic [1:0]  code;
  logic [31:0] wdat, rdat, rnd, q, c0, base;
  int          miscompares, checkCount, n;
  always #10 clk = ~clk;
  timer_cc_core #(.NUM_CH(8)) dut_u (
    .clk(clk), .rst_b(rst_b), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .chIrq(chIrq), .paInputIrq(paIn), .paOverflowIrq(pulse_overflow_flag),
    .counterOverflowIrq(cntOvf));
  timer_pin_model pm (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction : xs
  function automatic logic act(input logic old, input logic [1:0] c);
    act = (c == timer_pkg::ACT_TOGGLE) ? ~old : c[0];
  endfunction : act
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rdChk
  task automatic stopTest;
    $display("checks=%0d miscompares=%0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stopTest
  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    stopTest();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    {rst_b, cyc, stb, we, adr, wdat} = '0;
    sel = 4'h3;
    rnd = 32'h1ADF;
    miscompares = 0;
    checkCount = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({chIrq, pinOe, pinOut, 5'h0, paIn, pulse_overflow_flag, cntOvf}, 32'h0);
    rdChk(timer_pkg::FLAGS_OFS, 32'h0);
    rdChk(8'hFC, 32'h0);
    // Channel 1 sets its pin at 0x30 while channel 7 matches too and masks pin 1 low.
    wr(timer_pkg::SELECT_OFS, 32'h82);
    wr(timer_pkg::ACTION_OFS, {28'h0, timer_pkg::ACT_SET, 2'h0});
    wr(timer_pkg::CHVAL_OFS + 8'h04, 32'h30);
    wr(timer_pkg::CHVAL_OFS + 8'h1C, 32'h30);
    wr(timer_pkg::CH7_OFS, 32'h0002);
    wr(timer_pkg::CHIRQEN_OFS, 32'h02);
    wr(timer_pkg::CTRL_OFS, 32'h03);
    repeat (80) @(posedge clk);
    chk(pinOut[1], 1'b0);
    chk({chIrq, pinOe}, 16'h0202);
    rd(timer_pkg::FLAGS_OFS, q);
    chk(q & 32'h82, 32'h82);
    rd(timer_pkg::COUNT_OFS, q);
    chk(q <= 32'h30, 1'b1);
    wr(timer_pkg::CH7_OFS, 32'h0);
    repeat (60) @(posedge clk);
    chk(pinOut[1], 1'b1);
    wr(timer_pkg::CTRL_OFS, 32'h0);
    wr(timer_pkg::FLAGS_OFS, 32'h1FF);
    rdChk(timer_pkg::FLAGS_OFS, 32'h0);
    // Port data 1 is parked in the latch while compare owns pin 1.
    wr(timer_pkg::PORT_OFS, 32'h0202);
    cur = 1'b1;
    for (int k = 0; k < 4; k++) begin
      code = (k == 3) ? timer_pkg::ACT_TOGGLE : 2'(k + 1);
      wr(timer_pkg::ACTION_OFS, {28'h0, code, 2'h0});
      wr(timer_pkg::FORCE_OFS, 32'h02);
      cur = act(cur, code);
      chk(pinOut[1], cur);
    end
    rdChk(timer_pkg::FLAGS_OFS, 32'h0);
    wr(timer_pkg::ACTION_OFS, 32'h0);
    chk(pinOut[1], 1'b1);
    wr(timer_pkg::PORT_OFS, 32'h0);
    // Capture on channel 2 rising edge with the counter running.
    wr(timer_pkg::SELECT_OFS, 32'h0);
    wr(timer_pkg::CAPTEDGE_OFS, 32'h10);
    wr(timer_pkg::CHIRQEN_OFS, 32'h04);
    wr(timer_pkg::CTRL_OFS, 32'h01);
    rd(timer_pkg::COUNT_OFS, c0);
    pm.pulse(2, 1, 4, 4);
    rd(timer_pkg::COUNT_OFS, base);
    rd(timer_pkg::CHVAL_OFS + 8'h08, q);
    wr(timer_pkg::CTRL_OFS, 32'h0);
    chk(q > c0 && q < base, 1'b1);
    chk(chIrq, 8'h04);
    rdChk(timer_pkg::FLAGS_OFS, 32'h04);
    wr(timer_pkg::FLAGS_OFS, 32'h1FF);
    // Channel 7 is left as capture with no action and no mask, timer off.
    for (int e = 0; e < 2; e++) begin
      wr(timer_pkg::PACTRL_OFS, 32'h13 | 32'(e << 2));
      rnd = xs(rnd);
      base = {17'h0, rnd[14:0]};
      n = int'(rnd[19:16]) + 1;
      wr(timer_pkg::PACOUNT_OFS, base);
      pm.src[7] <= 1'b1;
      repeat (6) @(posedge clk);
      rdChk(timer_pkg::PACOUNT_OFS, 32'(base + e));
      pm.src[7] <= 1'b0;
      repeat (6) @(posedge clk);
      pm.pulse(7, n, 3 + int'(rnd[21:20]), 3 + int'(rnd[23:22]));
      repeat (6) @(posedge clk);
      rdChk(timer_pkg::PACOUNT_OFS, 32'(base + n + 1));
    end
    wr(timer_pkg::PAFLAG_OFS, 32'h0);
    chk(paIn, 1'b1);
    wr(timer_pkg::PAFLAG_OFS, 32'h1);
    chk(paIn, 1'b0);
    wr(timer_pkg::PACOUNT_OFS, 32'hFFFF);
    pm.pulse(7, 1, 3, 6);
    rdChk(timer_pkg::PACOUNT_OFS, 32'h0);
    chk(pulse_overflow_flag, 1'b1);
    wr(timer_pkg::PAFLAG_OFS, 32'h2);
    chk(pulse_overflow_flag, 1'b0);
    // Gated mode with the timer off must not count at all.
    wr(timer_pkg::PACTRL_OFS, 32'h1B);
    wr(timer_pkg::PACOUNT_OFS, 32'h0);
    pm.src[7] <= 1'b1;
    repeat (200) @(posedge clk);
    pm.src[7] <= 1'b0;
    rdChk(timer_pkg::PACOUNT_OFS, 32'h0);
    wr(timer_pkg::CTRL_OFS, 32'h01);
    for (int e = 0; e < 2; e++) begin
      pm.src[7] <= e[0];
      wr(timer_pkg::PACTRL_OFS, 32'h1B | 32'(e << 2));
      wr(timer_pkg::PAFLAG_OFS, 32'h3);
      wr(timer_pkg::PACOUNT_OFS, 32'h0);
      pm.src[7] <= ~e[0];
      repeat (256) @(posedge clk);
      pm.src[7] <= e[0];
      repeat (6) @(posedge clk);
      rdChk(timer_pkg::PACOUNT_OFS, 32'h4);
      chk(paIn, 1'b1);
      rdChk(timer_pkg::PAFLAG_OFS, 32'h1);
    end
    // The free-running counter wraps within 65536 prescale-1 ticks.
    wr(timer_pkg::CTRL_OFS, 32'h21);
    repeat (65600) @(posedge clk);
    chk(cntOvf, 1'b1);
    rdChk(timer_pkg::FLAGS_OFS, 32'h100);
    stopTest();
  end
endmodule : timer_capture_compare_pulse_accum_tb
`default_nettype wire

/* verif/timer_pin_model.sv */
// Pin-side model: event sources on the timer pins, loaded by what the block drives.
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
  // Clock
  input  wire logic       clk,
  // Block side of the pins
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  output logic      [7:0] pinIn
);
  // ****************
  // Pin levels
  // ****************
  logic [7:0] src = 8'h00;
  // A pin that the block drives reads back the driven level, as the pad would.
  assign pinIn = (pinOe & pinOut) | (~pinOe & src);
  // Each pulse leaves the idle level and returns, so it makes one edge of each kind.
  task automatic pulse(input int ch, input int cnt, input int hi, input int lo);
    for (int k = 0; k < cnt; k++) begin
      src[ch] <= ~src[ch];
      repeat (hi) @(posedge clk);
      src[ch] <= ~src[ch];
      repeat (lo) @(posedge clk);
    end
  endtask : pulse
endmodule : timer_pin_model
`default_nettype wire
